// ===== pkg/rcs_defs.svh
// Constants for the radio setup register bank
// Notes on behaviour
// - Undefined bit positions always read back as zero, whatever was written.
// - Setup bits 6,5,4 mask receive-ready, sent, retry-limit interrupts; reset 0.
// - Setup bit 3 checksum enable, reset 1, forced 1 by any auto-ack; bit 2 length.
// - Setup bit 1 powers up when 1; bit 0 selects receiver role; both reset 0.
// - Auto-ack bits 5..0 enable pipes 5..0, reset 1; bits 7:6 stay zero.
// - Interrupt line goes active on unmasked flag set, inactive when flag cleared by 1.
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

`define RCS_ADDR_SETUP 5'h00
`define RCS_ADDR_AUTOACK 5'h01
`define RCS_ADDR_RXPIPE 5'h02
`define RCS_ADDR_STATUS 5'h07

`define RCS_CMD_READ 3'h0
`define RCS_CMD_WRITE 3'h1

`define RCS_BIT_MASK_RX 6
`define RCS_BIT_MASK_TX 5
`define RCS_BIT_MASK_RT 4
`define RCS_BIT_CRC_EN 3
`define RCS_BIT_CRC_LEN 2
`define RCS_BIT_PWR 1
`define RCS_BIT_ROLE 0

`define RCS_BIT_FLAG_RX 6
`define RCS_BIT_FLAG_TX 5
`define RCS_BIT_FLAG_RT 4

`define RCS_RST_SETUP 7'h08
`define RCS_RST_AUTOACK 6'h3f
`define RCS_RST_RXPIPE 6'h03
`define RCS_RST_PINS 3'h2

`endif

// ===== pkg/rcs_pkg.sv
// Types for the radio setup register bank
package rcs_pkg;
    typedef struct packed {
        logic recv_ready_irq_mask;
        logic sent_irq_mask;
        logic retry_limit_irq_mask;
        logic checksum_enable;
        logic checksum_length_select;
        logic power_state_bit;
        logic role_select;
        logic [5:0] autoack_pipe_enable;
        logic [5:0] rx_pipe_enable;
    } rcs_cfg_t;

    typedef struct packed {
        logic recv_ready_flag;
        logic sent_flag;
        logic retry_limit_flag;
    } rcs_flags_t;
endpackage

// ===== src/rcs_setup_regs.sv
// Radio setup registers behind a serial register port
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defs.svh"

module rcs_setup_regs (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic spi_sck_in,
    input wire logic spi_csn_in,
    input wire logic spi_mosi_in,
    input wire logic recv_ready_set_in,
    input wire logic sent_set_in,
    input wire logic retry_limit_set_in,
    output logic spi_miso_out,
    output logic radio_interrupt_line_n_out,
    output var rcs_pkg::rcs_cfg_t cfg_out,
    output var rcs_pkg::rcs_flags_t flags_out
);

    // Pin synchronisers, two flops per pin
    localparam int PIN_CNT = 3;
    localparam logic [PIN_CNT-1:0] PIN_IDLE = `RCS_RST_PINS;
    wire logic [PIN_CNT-1:0] pin_raw = {spi_sck_in, spi_csn_in, spi_mosi_in};
    wire logic [PIN_CNT-1:0] pin_sync;

    for (genvar p = 0; p < PIN_CNT; p++) begin : g_pin_sync
        logic [1:0] sync_reg;
        always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                sync_reg <= PIN_IDLE[p] ? 2'h3 : 2'h0;
            end else begin
                sync_reg <= {sync_reg[0], pin_raw[p]};
            end
        end
        assign pin_sync[p] = sync_reg[1];
    end

    wire logic sck_s = pin_sync[2];
    wire logic csn_s = pin_sync[1];
    wire logic mosi_s = pin_sync[0];

    // Edge detection on the synchronised pins
    logic sck_prev_reg;
    logic csn_prev_reg;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sck_prev_reg <= 1'b0;
            csn_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_s;
            csn_prev_reg <= csn_s;
        end
    end

    wire logic frame_start = csn_prev_reg & ~csn_s;
    wire logic active = ~csn_s;
    wire logic sck_rise = active & sck_s & ~sck_prev_reg;
    wire logic sck_fall = active & ~sck_s & sck_prev_reg;

    // Register storage
    logic [6:0] setup_reg;
    logic [5:0] autoack_reg;
    logic [5:0] rxpipe_reg;
    wire logic [2:0] flags_now;

    // Serial engine state
    logic [2:0] bit_cnt_reg;
    logic first_byte_reg;
    logic data_seen_reg;
    logic [7:0] cmd_reg;
    logic [6:0] shift_in_reg;
    logic [7:0] tx_reg;
    logic [7:0] tx_next_reg;

    wire logic byte_done = sck_rise & (bit_cnt_reg == 3'h7);
    wire logic [7:0] rx_byte = {shift_in_reg, mosi_s};
    wire logic [4:0] cmd_addr = first_byte_reg ? rx_byte[4:0] : cmd_reg[4:0];
    wire logic cmd_is_read = rx_byte[7:5] == `RCS_CMD_READ;
    wire logic cmd_is_write = cmd_reg[7:5] == `RCS_CMD_WRITE;
    wire logic wr_en = byte_done & ~first_byte_reg & cmd_is_write & ~data_seen_reg;
    wire logic wr_setup = wr_en & (cmd_reg[4:0] == `RCS_ADDR_SETUP);
    wire logic wr_autoack = wr_en & (cmd_reg[4:0] == `RCS_ADDR_AUTOACK);
    wire logic wr_rxpipe = wr_en & (cmd_reg[4:0] == `RCS_ADDR_RXPIPE);
    wire logic wr_status = wr_en & (cmd_reg[4:0] == `RCS_ADDR_STATUS);
    wire logic rd_cmd = first_byte_reg ? cmd_is_read : (cmd_reg[7:5] == `RCS_CMD_READ);

    // Effective checksum enable
    wire logic crc_eff = setup_reg[`RCS_BIT_CRC_EN] | (|autoack_reg);

    // Address decode for reads
    wire logic sel_setup = cmd_addr == `RCS_ADDR_SETUP;
    wire logic sel_autoack = cmd_addr == `RCS_ADDR_AUTOACK;
    wire logic sel_rxpipe = cmd_addr == `RCS_ADDR_RXPIPE;
    wire logic sel_status = cmd_addr == `RCS_ADDR_STATUS;

    wire logic [7:0] setup_rd = {1'b0, setup_reg[6:4], crc_eff, setup_reg[2:0]};
    wire logic [7:0] status_rd = {1'b0, flags_now, 4'h0};
    wire logic [7:0] rd_data =
        sel_setup ? setup_rd :
        sel_autoack ? {2'h0, autoack_reg} :
        sel_rxpipe ? {2'h0, rxpipe_reg} :
        sel_status ? status_rd :
        8'h00;

    // Flag set and clear per source; set wins
    wire logic [2:0] flag_set = {recv_ready_set_in, sent_set_in, retry_limit_set_in};
    wire logic [2:0] flag_clr = wr_status ? rx_byte[6:4] : 3'h0;
    wire logic [2:0] irq_masks = setup_reg[6:4];
    wire logic [2:0] flags_next;
    wire logic [2:0] irq_pend;

    for (genvar f = 0; f < 3; f++) begin : g_flag
        logic flag_reg;
        assign flags_next[f] = flag_set[f] | (flag_reg & ~flag_clr[f]);
        assign irq_pend[f] = flags_next[f] & ~irq_masks[f];
        always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                flag_reg <= 1'b0;
            end else begin
                flag_reg <= flags_next[f];
            end
        end
        assign flags_now[f] = flag_reg;
    end

    wire logic irq_next = ~(|irq_pend);

    // Register writes
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            setup_reg <= `RCS_RST_SETUP;
        end else if (wr_setup) begin
            setup_reg <= rx_byte[6:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            autoack_reg <= `RCS_RST_AUTOACK;
        end else if (wr_autoack) begin
            autoack_reg <= rx_byte[5:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rxpipe_reg <= `RCS_RST_RXPIPE;
        end else if (wr_rxpipe) begin
            rxpipe_reg <= rx_byte[5:0];
        end
    end

    // Interrupt line, active low
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            radio_interrupt_line_n_out <= 1'b1;
        end else begin
            radio_interrupt_line_n_out <= irq_next;
        end
    end

    // Command decode and receive shifting
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bit_cnt_reg <= 3'h0;
            first_byte_reg <= 1'b1;
            data_seen_reg <= 1'b0;
            cmd_reg <= 8'hff;
            shift_in_reg <= 7'h00;
            tx_next_reg <= 8'h00;
        end else if (frame_start) begin
            bit_cnt_reg <= 3'h0;
            first_byte_reg <= 1'b1;
            data_seen_reg <= 1'b0;
            cmd_reg <= 8'hff;
        end else if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_in_reg <= rx_byte[6:0];
            if (byte_done) begin
                first_byte_reg <= 1'b0;
                data_seen_reg <= ~first_byte_reg;
                if (first_byte_reg) begin
                    cmd_reg <= rx_byte;
                end
                tx_next_reg <= rd_cmd ? rd_data : 8'h00;
            end
        end
    end

    // Transmit shifting, status first
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_reg <= 8'h00;
        end else if (frame_start) begin
            tx_reg <= status_rd;
        end else if (sck_fall) begin
            tx_reg <= (bit_cnt_reg == 3'h0) ? tx_next_reg : {tx_reg[6:0], 1'b0};
        end
    end

    assign spi_miso_out = tx_reg[7];

    // Registered configuration view
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_out <= '0;
            flags_out <= '0;
        end else begin
            cfg_out.recv_ready_irq_mask <= setup_reg[`RCS_BIT_MASK_RX];
            cfg_out.sent_irq_mask <= setup_reg[`RCS_BIT_MASK_TX];
            cfg_out.retry_limit_irq_mask <= setup_reg[`RCS_BIT_MASK_RT];
            cfg_out.checksum_enable <= crc_eff;
            cfg_out.checksum_length_select <= setup_reg[`RCS_BIT_CRC_LEN];
            cfg_out.power_state_bit <= setup_reg[`RCS_BIT_PWR];
            cfg_out.role_select <= setup_reg[`RCS_BIT_ROLE];
            cfg_out.autoack_pipe_enable <= autoack_reg;
            cfg_out.rx_pipe_enable <= rxpipe_reg;
            flags_out <= flags_now;
        end
    end

endmodule // rcs_setup_regs

`default_nettype wire

// ===== verification/rcs_setup_regs_checker.sv
// Assertions for the radio setup register bank
`timescale 1ns/1ps
`default_nettype none
module rcs_setup_regs_checker (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic spi_csn_in,
    input wire logic recv_ready_set_in,
    input wire logic sent_set_in,
    input wire logic retry_limit_set_in,
    input wire logic radio_interrupt_line_n_out,
    input wire rcs_pkg::rcs_cfg_t cfg_out,
    input wire rcs_pkg::rcs_flags_t flags_out
);
    wire [2:0] set_v = {recv_ready_set_in, sent_set_in, retry_limit_set_in};
    wire [2:0] mask_v = {cfg_out.recv_ready_irq_mask, cfg_out.sent_irq_mask,
        cfg_out.retry_limit_irq_mask};
    wire pend = |(flags_out & ~mask_v);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence idle_s;
        spi_csn_in [*8];
    endsequence
    rst_vals_a: assert property (
        $past(sys_rst_in, 2) && !$past(sys_rst_in) |-> cfg_out == {7'h08, 6'h3f, 6'h03})
        else $error("bad reset value");
    crc_forced_a: assert property (
        |cfg_out.autoack_pipe_enable |-> cfg_out.checksum_enable)
        else $error("checksum not forced");
    irq_on_a: assert property (
        pend && $stable(mask_v) |-> !$past(radio_interrupt_line_n_out))
        else $error("irq not raised");
    irq_off_a: assert property (
        !pend && $stable(mask_v) |-> $past(radio_interrupt_line_n_out))
        else $error("irq not released");
    flag_set_a: assert property (
        |set_v |=> ##1 ((flags_out & $past(set_v, 2)) == $past(set_v, 2)))
        else $error("flag not set");
    flag_src_a: assert property (
        (flags_out & ~$past(flags_out) & ~$past(set_v, 2)) == 3'h0) else $error("stray flag");
    cfg_hold_a: assert property (
        idle_s |=> $stable(cfg_out)) else $error("config moved while idle");
endmodule // rcs_setup_regs_checker
`default_nettype wire

// ===== verification/rcs_spi_master.sv
// Controller model issuing register frames
`timescale 1ns/1ps
`default_nettype none
module rcs_spi_master (
    output logic spi_sck_out,
    output logic spi_csn_out,
    output logic spi_mosi_out,
    input wire logic spi_miso_in
);
    initial begin
        spi_sck_out = 0;
        spi_csn_out = 1;
        spi_mosi_out = 0;
    end
    task automatic xfer(input logic [7:0] c, d, output logic [7:0] st, rd);
        logic [15:0] tx;
        logic [15:0] rx;
        tx = {c, d};
        if (c[7:5] == 3'h1 && c[4:3] == 2'h3 && c[2] == 1'b0) tx[15:8] = 8'hff;
        spi_csn_out <= 0;
        #64;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi_out <= tx[i];
            #32 spi_sck_out <= 1;
            #28 rx[i] = spi_miso_in;
            #4 spi_sck_out <= 0;
        end
        #160 spi_csn_out <= 1;
        spi_mosi_out <= ~spi_mosi_out;
        #200;
        st = rx[15:8];
        rd = rx[7:0];
    endtask
endmodule // rcs_spi_master
`default_nettype wire

// ===== verification/radio_core_setup_registers_test.sv
// Self-checking bench for the radio setup register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module radio_core_setup_registers_test;
    logic ref_clk_in = 0, sys_rst_in = 1, spi_sck_in, spi_csn_in, spi_mosi_in, spi_miso_out;
    logic recv_ready_set_in = 0, sent_set_in = 0, retry_limit_set_in = 0;
    logic radio_interrupt_line_n_out;
    rcs_pkg::rcs_cfg_t cfg_out;
    rcs_pkg::rcs_flags_t flags_out;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    logic [7:0] st, rd, v, regs[3], e[3];
    logic [2:0] mfl = 0;
    rcs_setup_regs i_rcs_setup_regs(.*);
    rcs_spi_master i_rcs_spi_master(.spi_sck_out(spi_sck_in), .spi_csn_out(spi_csn_in),
        .spi_mosi_out(spi_mosi_in), .spi_miso_in(spi_miso_out));
    initial forever #4 ref_clk_in = ~ref_clk_in;
    task stop_test;
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            stop_test;
        end
    end
    task xf(input logic [7:0] c, d);
        i_rcs_spi_master.xfer(c, d, st, rd);
    endtask
    task chk_all;
        e[0] = regs[0] & 8'h7f | ((regs[1] & 8'h3f) != 0 ? 8'h08 : 8'h00);
        e[1] = regs[1] & 8'h3f;
        e[2] = regs[2] & 8'h3f;
        for (int a = 0; a < 3; a++) begin
            xf(8'(a), 8'h00);
            `CHK(rd, e[a])
            `CHK(st, {1'b0, mfl, 4'h0})
        end
        `CHK(cfg_out, {e[0][6:0], e[1][5:0], e[2][5:0]})
    endtask
    initial begin
        v = $urandom(48);
        regs = '{8'h08, 8'h3f, 8'h03};
        repeat (10) @(posedge ref_clk_in);
        sys_rst_in <= 0;
        repeat (2) @(posedge ref_clk_in);
        chk_all;
        for (int i = 0; i < 6; i++) begin
            for (int a = 0; a < 3; a++) begin
                v = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
                xf(8'h20 | 8'(a), v);
                regs[a] = v;
            end
            chk_all;
        end
        xf(8'h25, 8'h5a);
        xf(8'h05, 8'h00);
        `CHK(rd, 8'h00)
        xf(8'hff, 8'h00);
        `CHK(rd, 8'h00)
        for (int f = 0; f < 3; f++) begin
            for (int m = 0; m < 2; m++) begin
                regs[0] = m ? 8'h70 : 8'h00;
                xf(8'h20, regs[0]);
                @(posedge ref_clk_in);
                {recv_ready_set_in, sent_set_in, retry_limit_set_in} <= 3'h4 >> f;
                @(posedge ref_clk_in);
                {recv_ready_set_in, sent_set_in, retry_limit_set_in} <= 3'h0;
                mfl = 3'h4 >> f;
                repeat (3) @(posedge ref_clk_in);
                `CHK(radio_interrupt_line_n_out, 1'(m))
                chk_all;
                xf(8'h07, 8'h00);
                `CHK(rd, {1'b0, mfl, 4'h0})
                xf(8'h27, {1'b0, mfl, 4'h0});
                mfl = 0;
                repeat (3) @(posedge ref_clk_in);
                `CHK(radio_interrupt_line_n_out, 1'b1)
            end
        end
        stop_test;
    end
endmodule // radio_core_setup_registers_test
bind rcs_setup_regs rcs_setup_regs_checker i_rcs_setup_regs_checker(.*);
`default_nettype wire
